// file: core/lsu_pkg.sv
// package of the line serial unit: register indices, field layout, reset values,
// frame formats and the small decode functions shared by the design.
// assumes a classic Wishbone slave with 32-bit data; register i sits at byte 4*i.
// Overview of operation
// - activation 0 keeps the state machine idle with no frame-buffer reads.
// - while idle, idle buffer select picks which buffer the processor reaches.
// - open-drain select: 0 push-pull, 1 open-drain on both serial outputs.
// - double clock select: 0 one bit per bit clock, 1 two clocks per bit.
// - rate select picks 1x6, 1x12, 2x32 or 1x64 slot frame formats.
// - control register resets to 02 hex: idle, single clock, push-pull, 2x32.
// - status bit 15 shows which buffer is the active port buffer.
// - buffer index changes as soon as the two buffers swap roles.
// - unused control and status bits read as zero.
// - mask bit 0 tri-states its slot group, 1 drives it; mask resets to 0.
// - group length, slots and output per mask bit follow the rate select.
// - in 6 and 12 slot formats bit n is slot n on first output only.
// - in 2x32 format bits 0-7 group four slots first line, 8-15 second.
// - in 64 slot format bit n covers slots 4n to 4n+3 on first output.
package lsu_pkg;
	// register indices (byte address is four times the index)
	localparam logic [15:0] LSU_IDX_CTRL = 16'hD040;
	localparam logic [15:0] LSU_IDX_STAT = 16'hD041;
	localparam logic [15:0] LSU_IDX_MASK_SET = 16'hD042;
	localparam logic [15:0] LSU_IDX_MASK_CLR = 16'hD043;
	localparam logic [15:0] LSU_IDX_MASK_RD = 16'hD044;
	// reset values and field layout
	localparam logic [15:0] LSU_CTRL_RST = 16'h0002;
	localparam logic [15:0] LSU_MASK_RST = 16'h0000;
	localparam logic [15:0] LSU_CTRL_USED = 16'h003F;
	localparam int LSU_CTRL_W = 6;
	localparam int LSU_STAT_IDX_BIT = 15;
	// buffer sizes
	localparam int LSU_FBUF_DEPTH = 64;
	localparam int LSU_FIFO_DEPTH = 8;
	localparam logic [5:0] LSU_LINE2_BASE = 6'h20;

	typedef enum logic [1:0] {
		RATE_1X6 = 2'b00,
		RATE_1X12 = 2'b01,
		RATE_2X32 = 2'b10,
		RATE_1X64 = 2'b11
	} lsu_rate_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_RUN = 2'b10,
		ST_DONE = 2'b11
	} lsu_state_e;

	// control fields, bit 5 down to bit 0
	typedef struct packed {
		logic idle_buffer_select;
		logic active;
		logic open_drain_select;
		logic double_clock_select;
		lsu_rate_e rate_select;
	} lsu_ctrl_s;

	typedef struct packed {
		logic valid;
		logic [3:0] idx;
	} lsu_mask_sel_s;

	// slots per line in the chosen format
	function automatic logic [6:0] lsu_slots_per_line(input lsu_rate_e r);
		unique case (r)
			RATE_1X6: return 7'h06;
			RATE_1X12: return 7'h0C;
			RATE_2X32: return 7'h20;
			RATE_1X64: return 7'h40;
		endcase
	endfunction : lsu_slots_per_line

	// bytes per frame over both lines
	function automatic logic [6:0] lsu_frame_bytes(input lsu_rate_e r);
		return (r == RATE_2X32) ? 7'h40 : lsu_slots_per_line(r);
	endfunction : lsu_frame_bytes

	// which mask bit governs a slot on a line
	function automatic lsu_mask_sel_s lsu_mask_index(input lsu_rate_e r, input logic line,
			input logic [5:0] slot);
		lsu_mask_sel_s s;
		s.valid = 1'b0;
		s.idx = 4'h0;
		unique case (r)
			RATE_1X6, RATE_1X12: begin
				s.valid = !line;
				s.idx = slot[3:0];
			end
			RATE_2X32: begin
				s.valid = 1'b1;
				s.idx = {line, slot[4:2]};
			end
			RATE_1X64: begin
				s.valid = !line;
				s.idx = slot[5:2];
			end
		endcase
		return s;
	endfunction : lsu_mask_index

	// byte-lane mask of a 16-bit register
	function automatic logic [15:0] lsu_lane_mask(input logic [1:0] sel);
		return {{8{sel[1]}}, {8{sel[0]}}};
	endfunction : lsu_lane_mask
endpackage : lsu_pkg

// file: core/lsu_line_serial_unit.sv
// line serial unit: Wishbone registers, ping-pong frame buffers fed through a FIFO,
// and the two-line slot serialiser with per-group tri-state control.
// assumes bit clock and frame sync pins are asynchronous and far slower than core_clk_i.
`timescale 1ns/100ps

module lsu_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic full_reg;
	logic empty_reg;
	wire push = in_valid_i && !full_reg;
	wire pop = out_ready_i && !empty_reg;

	// flags are flops so in_ready_o and out_valid_o come straight from registers
	assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign in_ready_o = !full_reg;
	assign out_valid_o = !empty_reg;
	assign out_data_o = mem[rd_reg];

	// storage has no reset, only pointers, count and flags do
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_reg] <= in_data_i;
		end
	end

	// pointers wrap at the power-of-two depth
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			full_reg <= 1'b0;
			empty_reg <= 1'b1;
		end else begin
			wr_reg <= wr_reg + AW'(push);
			rd_reg <= rd_reg + AW'(pop);
			cnt_reg <= cnt_next;
			full_reg <= (cnt_next == (AW+1)'(D));
			empty_reg <= (cnt_next == '0);
		end
	end
endmodule : lsu_fifo

module lsu_line_serial_unit import lsu_pkg::*; #(
	parameter int ADR_W = 18,
	parameter int FIFO_DEPTH = LSU_FIFO_DEPTH
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// processor frame data stream into the processor-side buffer
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	// serial bus pins
	input wire logic bit_clock_pin_i,
	input wire logic frame_sync_i,
	output logic serial_out_first_o,
	output logic serial_out_first_oe_n_o,
	output logic serial_out_second_o,
	output logic serial_out_second_oe_n_o
);
	logic [15:0] ctrl_reg;
	logic [15:0] mask_reg;
	logic [31:0] dat_reg;
	logic ack_reg;
	lsu_state_e state_reg;
	lsu_state_e state_next;
	logic buf_idx_reg;
	logic buf_idx_next;
	logic [5:0] slot_reg;
	logic [5:0] slot_next;
	logic [2:0] bit_reg;
	logic [2:0] bit_next;
	logic phase_reg;
	logic dc_prev_adv_reg;
	logic [6:0] wr_ptr_reg;
	logic [2:0] bclk_sync;
	logic [2:0] fs_sync;
	logic [1:0] out_reg;
	logic [1:0] oe_n_reg;
	logic [7:0] fbuf [0:1][0:LSU_FBUF_DEPTH-1];
	logic fifo_valid;
	logic [7:0] fifo_data;
	lsu_ctrl_s ctrl;

	// bus decode
	wire [15:0] adr_idx = wb_adr_i[17:2];
	wire req = wb_cyc_i && wb_stb_i && !ack_reg;
	wire wr = req && wb_we_i;
	wire hit_ctrl = (adr_idx == LSU_IDX_CTRL);
	wire hit_stat = (adr_idx == LSU_IDX_STAT);
	wire hit_set = (adr_idx == LSU_IDX_MASK_SET);
	wire hit_clr = (adr_idx == LSU_IDX_MASK_CLR);
	wire hit_mrd = (adr_idx == LSU_IDX_MASK_RD);
	wire [15:0] lanes = lsu_lane_mask(wb_sel_i[1:0]);
	wire [15:0] wdat = wb_dat_i[15:0] & lanes;
	wire [15:0] ctrl_wr = ((ctrl_reg & ~lanes) | wdat) & LSU_CTRL_USED;
	wire [15:0] stat_word = {buf_idx_reg, 15'h0000};
	wire [15:0] rd_word = hit_ctrl ? ctrl_reg :
			hit_stat ? stat_word :
			(hit_set || hit_clr || hit_mrd) ? mask_reg : 16'h0000;
	assign ctrl = lsu_ctrl_s'(ctrl_reg[LSU_CTRL_W-1:0]);

	// pin synchronisers; stage 0 feeds only stage 1
	wire clk_rise = bclk_sync[1] && !bclk_sync[2];
	wire fs_rise = fs_sync[1] && !fs_sync[2];

	// frame timing
	wire [6:0] spl = lsu_slots_per_line(ctrl.rate_select);
	wire last_slot = ({1'b0, slot_reg} == spl - 7'h01);
	wire frame_start = fs_rise && ctrl.active && (state_reg != ST_IDLE);
	// double clock advances on every second rising edge only
	wire bit_adv = (state_reg == ST_RUN) && clk_rise && !fs_rise &&
			(!ctrl.double_clock_select || phase_reg);
	wire frame_end = bit_adv && (bit_reg == 3'h7) && last_slot;

	// state machine: idle without activation, waits for the first frame sync
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (ctrl.active) state_next = ST_WAIT;
			ST_WAIT, ST_RUN, ST_DONE: begin
				if (!ctrl.active) begin
					state_next = ST_IDLE;
				end else if (frame_start) begin
					state_next = ST_RUN;
				end else if (frame_end) begin
					state_next = ST_DONE;
				end
			end
		endcase
	end

	// buffer roles: chosen by software when idle, swapped at each frame start
	always_comb begin
		buf_idx_next = buf_idx_reg;
		if (state_reg == ST_IDLE) begin
			buf_idx_next = !ctrl.idle_buffer_select;
		end else if (frame_start) begin
			buf_idx_next = !buf_idx_reg;
		end
	end

	// slot and bit pointer, msb of each slot first
	always_comb begin
		slot_next = slot_reg;
		bit_next = bit_reg;
		if (frame_start) begin
			slot_next = 6'h00;
			bit_next = 3'h0;
		end else if (bit_adv && !last_slot && (bit_reg == 3'h7)) begin
			slot_next = slot_reg + 6'h01;
			bit_next = 3'h0;
		end else if (bit_adv && (bit_reg != 3'h7)) begin
			bit_next = bit_reg + 3'h1;
		end
	end

	// output bit and drive decision per line
	wire run_nx = (state_next == ST_RUN);
	wire [5:0] adr_first = slot_next;
	wire [5:0] adr_second = slot_next | LSU_LINE2_BASE;
	wire [7:0] byte_first = fbuf[buf_idx_next][adr_first];
	wire [7:0] byte_second = fbuf[buf_idx_next][adr_second];
	wire [2:0] bit_pos = 3'h7 - bit_next;
	wire [1:0] bit_val = {byte_second[bit_pos], byte_first[bit_pos]};
	wire lsu_mask_sel_s sel_first = lsu_mask_index(ctrl.rate_select, 1'b0, slot_next);
	wire lsu_mask_sel_s sel_second = lsu_mask_index(ctrl.rate_select, 1'b1, slot_next);
	wire [1:0] drive = {run_nx && sel_second.valid && mask_reg[sel_second.idx],
			run_nx && sel_first.valid && mask_reg[sel_first.idx]};
	// open drain pulls low only, a one is left to the bus pull-up
	wire [1:0] out_nx = ctrl.open_drain_select ? 2'b00 : (bit_val & drive);
	wire [1:0] oe_n_nx = ctrl.open_drain_select ? ~(drive & ~bit_val) : ~drive;

	// fifo drain into the processor buffer, stalled when full for this frame or at a swap
	wire proc_buf = !buf_idx_reg;
	wire drain_ready = (wr_ptr_reg < lsu_frame_bytes(ctrl.rate_select)) &&
			(buf_idx_next == buf_idx_reg);
	wire drain = fifo_valid && drain_ready;

	lsu_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(tx_valid_i),
		.in_data_i(tx_data_i),
		.in_ready_o(tx_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(drain_ready)
	);

	// frame buffer storage, written only on the processor side
	always_ff @(posedge core_clk_i) begin
		if (drain) begin
			fbuf[proc_buf][wr_ptr_reg[5:0]] <= fifo_data;
		end
	end

	// register file and bus answer one cycle after the strobe
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_reg <= LSU_CTRL_RST;
			mask_reg <= LSU_MASK_RST;
			dat_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
			if (req) begin
				dat_reg <= {16'h0000, rd_word};
			end
			if (wr && hit_ctrl) begin
				ctrl_reg <= ctrl_wr;
			end
			if (wr && hit_set) begin
				mask_reg <= mask_reg | wdat;
			end else if (wr && hit_clr) begin
				mask_reg <= mask_reg & ~wdat;
			end
		end
	end

	// serial engine state
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			buf_idx_reg <= 1'b1;
			slot_reg <= 6'h00;
			bit_reg <= 3'h0;
			phase_reg <= 1'b0;
			wr_ptr_reg <= 7'h00;
			bclk_sync <= 3'h0;
			fs_sync <= 3'h0;
			out_reg <= 2'b00;
			oe_n_reg <= 2'b11;
		end else begin
			bclk_sync <= {bclk_sync[1:0], bit_clock_pin_i};
			fs_sync <= {fs_sync[1:0], frame_sync_i};
			state_reg <= state_next;
			buf_idx_reg <= buf_idx_next;
			slot_reg <= slot_next;
			bit_reg <= bit_next;
			if (frame_start) begin
				phase_reg <= 1'b0;
			end else if (clk_rise && ctrl.double_clock_select) begin
				phase_reg <= !phase_reg;
			end
			if (buf_idx_next != buf_idx_reg) begin
				wr_ptr_reg <= 7'h00;
			end else if (drain) begin
				wr_ptr_reg <= wr_ptr_reg + 7'h01;
			end
			out_reg <= out_nx;
			oe_n_reg <= oe_n_nx;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign serial_out_first_o = out_reg[0];
	assign serial_out_second_o = out_reg[1];
	assign serial_out_first_oe_n_o = oe_n_reg[0];
	assign serial_out_second_oe_n_o = oe_n_reg[1];

	// check helper: whether the last bit clock rise advanced a bit under double clock,
	// kept apart from phase_reg so the pace check does not lean on the logic it guards
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dc_prev_adv_reg <= 1'b0;
		end else if (frame_start) begin
			dc_prev_adv_reg <= 1'b0;
		end else if (clk_rise) begin
			dc_prev_adv_reg <= bit_adv && ctrl.double_clock_select;
		end
	end

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	chk_idle_no_drive: assert property (
		(state_reg == ST_IDLE) && !ctrl.active |=> (oe_n_reg == 2'b11) && (state_reg == ST_IDLE))
		else $error("idle unit drives a serial output");
	chk_idle_buf_pick: assert property (
		(state_reg == ST_IDLE) |=> (buf_idx_reg == !$past(ctrl.idle_buffer_select)))
		else $error("idle buffer select not applied");
	chk_open_drain_low: assert property (
		$past(ctrl.open_drain_select) && $past(state_reg != ST_IDLE) |-> (out_reg == 2'b00))
		else $error("open drain output drives high");
	chk_dc_bit_pace: assert property (
		bit_adv && ctrl.double_clock_select |-> !dc_prev_adv_reg)
		else $error("double clock advanced on two rises in a row");
	chk_slot_in_frame: assert property (
		(state_reg == ST_RUN) && $stable(ctrl.rate_select) |-> ({1'b0, slot_reg} < spl))
		else $error("slot counter beyond frame length");
	chk_ctrl_reset_val: assert property (disable iff (1'b0)
		$rose(rstn_i) |-> (ctrl_reg == LSU_CTRL_RST) && (mask_reg == LSU_MASK_RST))
		else $error("control or mask reset value wrong");
	chk_swap_index: assert property (
		frame_start |=> (buf_idx_reg != $past(buf_idx_reg)) ##1 $stable(buf_idx_reg) || fs_rise)
		else $error("buffer index did not follow swap");
	chk_stat_zero_bits: assert property (
		ack_reg && $past(hit_stat && !wb_we_i) |-> (wb_dat_o[31:16] == 16'h0000) &&
			(wb_dat_o[14:0] == 15'h0000) && (wb_dat_o[LSU_STAT_IDX_BIT] == $past(buf_idx_reg)))
		else $error("status read shows wrong bits");
	chk_mask_set_or: assert property (
		wr && hit_set |=> mask_reg == ($past(mask_reg) | $past(wdat)))
		else $error("mask set write wrong");
	chk_mask_clr_andn: assert property (
		wr && hit_clr |=> mask_reg == ($past(mask_reg) & ~$past(wdat)))
		else $error("mask clear write wrong");
	chk_second_line_fmt: assert property (
		!oe_n_reg[1] |-> ($past(ctrl.rate_select) == RATE_2X32) && ($past(mask_reg[15:8]) != 8'h00))
		else $error("second line driven outside two-line format");
	chk_mask_gates_first: assert property (
		!oe_n_reg[0] |-> ($past(mask_reg[sel_first.idx]) && $past(sel_first.valid)))
		else $error("first line driven with mask bit clear");

	cov_frame_swap: cover property (frame_start ##[1:1000] frame_start);
	cov_mask_set: cover property (wr && hit_set ##2 !oe_n_reg[0]);
	cov_dc_run: cover property (bit_adv && ctrl.double_clock_select);
	cov_fifo_full: cover property (!tx_ready_o);
endmodule : lsu_line_serial_unit

// file: verif/lsu_line_card_model.sv
// line card model: makes bit clock and frame sync, resolves the pulled-up data wires
// assumes the unit's outputs settle within a few core cycles of a bit clock rise
`timescale 1ns/100ps

module lsu_line_card_model (
	// clock
	input wire logic core_clk_i,
	// unit outputs
	input wire logic first_i,
	input wire logic first_oe_n_i,
	input wire logic second_i,
	input wire logic second_oe_n_i,
	// bus timing made by the card
	output logic bit_clock_o,
	output logic frame_sync_o
);
	logic [7:0] cap1 [0:31];
	logic [7:0] cap2 [0:31];
	logic drv_one = 1'b0;
	wire wire1;
	wire wire2;

	// pull-ups: a released line reads high, never the last driven bit
	assign wire1 = first_oe_n_i ? 1'b1 : first_i;
	assign wire2 = second_oe_n_i ? 1'b1 : second_i;

	initial begin
		bit_clock_o = 1'b0;
		frame_sync_o = 1'b0;
	end

	// one frame; the clock stands still outside it. a bit stands from one advancing rise
	// to the next, so it is taken just before a rise; with double clock only every
	// second rise advances, so only every second clock period is sampled
	task automatic frame(input int nbits, input logic dc);
		int k;
		int n;
		drv_one = 1'b0;
		@(posedge core_clk_i);
		frame_sync_o <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		frame_sync_o <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		for (k = 0; k < (dc ? 2 * nbits : nbits); k++) begin
			if (!dc || k % 2 == 0) begin
				n = dc ? k / 2 : k;
				cap1[n / 8][7 - n % 8] = wire1;
				cap2[n / 8][7 - n % 8] = wire2;
				drv_one = drv_one | (!first_oe_n_i && first_i);
			end
			bit_clock_o <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			bit_clock_o <= 1'b0;
			repeat (8) @(posedge core_clk_i);
		end
	endtask : frame
endmodule : lsu_line_card_model

// file: verif/tb_top.sv
// self-checking bench of the line serial unit: registers, fifo fill, ping-pong frames
// assumes the line card model supplies bit clock and frame sync on request
`timescale 1ns/100ps

module tb_top;
	import lsu_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [17:0] adr = 18'h00000;
	logic [31:0] wdat = 32'h00000000;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	wire [31:0] wb_dat_o;
	wire wb_ack_o;
	wire tx_ready_o;
	wire bclk;
	wire fsync;
	wire out1;
	wire oe1_n;
	wire out2;
	wire oe2_n;
	int err_count = 0;
	int checks = 0;
	int i;
	logic [15:0] v;
	logic [15:0] w;
	logic [15:0] m;
	logic [15:0] c;
	logic [7:0] q [$];

	always #10 clk = ~clk;

	lsu_line_serial_unit uut (.core_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready_o), .bit_clock_pin_i(bclk), .frame_sync_i(fsync),
		.serial_out_first_o(out1), .serial_out_first_oe_n_o(oe1_n),
		.serial_out_second_o(out2), .serial_out_second_oe_n_o(oe2_n));

	lsu_line_card_model card (.core_clk_i(clk), .first_i(out1), .first_oe_n_i(oe1_n),
		.second_i(out2), .second_oe_n_i(oe2_n), .bit_clock_o(bclk), .frame_sync_o(fsync));

	task automatic end_of_test();
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one classic cycle; the request stands until ack is sampled high
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] d,
			output logic [15:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {idx, 2'b00};
		wdat <= {16'h0000, d};
		@(posedge clk);
		while (wb_ack_o !== 1'b1) @(posedge clk);
		r = wb_dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	// expected slot byte on a line: an undriven slot reads as the pull-up; in the
	// two-line format a mask bit covers four slots and the second line uses bits 8 up
	function automatic logic [7:0] slot_exp(input int base, input int line, input int s,
			input logic wide);
		int b;
		b = wide ? line * 8 + s / 4 : s;
		if (base < 0 || (line != 0 && !wide) || !m[b])
			return 8'hFF;
		return q[base + line * 32 + s];
	endfunction : slot_exp

	task automatic chk_frame(input int base, input logic pp, input int nslots,
			input logic wide);
		int s;
		for (s = 0; s < nslots; s++) begin
			chk({8'h00, card.cap1[s]}, {8'h00, slot_exp(base, 0, s, wide)});
			chk({8'h00, card.cap2[s]}, {8'h00, slot_exp(base, 1, s, wide)});
		end
		chk({15'h0000, card.drv_one}, {15'h0000, pp});
	endtask : chk_frame

	// watchdog: three short frames, one double-clock two-line frame of about 8200
	// cycles and the register work fit well inside this span
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	initial begin
		void'($urandom(52));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, LSU_IDX_CTRL, 16'h0000, v);
		chk(v, 16'h0002);
		bus(1'b0, LSU_IDX_MASK_RD, 16'h0000, v);
		chk(v, 16'h0000);
		bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
		chk(v, 16'h8000);
		// random control words with activation kept off
		for (i = 0; i < 6; i++) begin
			w = 16'($urandom);
			w[4] = 1'b0;
			bus(1'b1, LSU_IDX_CTRL, w, v);
			bus(1'b0, LSU_IDX_CTRL, 16'h0000, v);
			chk(v, w & 16'h003F);
			bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
			chk(v, {~w[5], 15'h0000});
		end
		bus(1'b1, LSU_IDX_STAT, 16'hFFFF, v);
		bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
		chk(v, {~w[5], 15'h0000});
		bus(1'b1, 16'hD047, 16'hFFFF, v);
		bus(1'b0, 16'hD047, 16'h0000, v);
		chk(v, 16'h0000);
		// set then clear, read back at all three addresses
		m = 16'($urandom);
		c = 16'($urandom);
		bus(1'b1, LSU_IDX_MASK_SET, m, v);
		bus(1'b1, LSU_IDX_MASK_CLR, c, v);
		m = m & ~c;
		for (i = 0; i < 3; i++) begin
			bus(1'b0, LSU_IDX_MASK_SET + 16'(i), 16'h0000, v);
			chk(v, m);
		end
		// 1x6 idle; unused high mask bits set on purpose
		bus(1'b1, LSU_IDX_CTRL, 16'h0000, v);
		bus(1'b1, LSU_IDX_MASK_CLR, 16'hFFFF, v);
		m = (16'($urandom) & 16'h003F) | 16'hFFC1;
		bus(1'b1, LSU_IDX_MASK_SET, m, v);
		// fill buffer and fifo until refused, then stall
		tx_valid <= 1'b1;
		tx_data <= 8'hA5;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (tx_ready_o === 1'b1) begin
				q.push_back(tx_data);
				tx_data <= 8'($urandom);
			end
		end
		tx_valid <= 1'b0;
		// six bytes fill the 1x6 buffer and eight stand in the fifo
		chk({15'h0000, tx_ready_o}, 16'h0000);
		chk(16'(q.size()), 16'h000E);
		// push-pull frame shows the first buffer
		bus(1'b1, LSU_IDX_CTRL, 16'h0010, v);
		card.frame(48, 1'b0);
		chk_frame(0, 1'b1, 6, 1'b0);
		bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
		chk(v, 16'h0000);
		// open-drain frame shows the refilled second buffer
		bus(1'b1, LSU_IDX_CTRL, 16'h0018, v);
		card.frame(48, 1'b0);
		chk_frame(6, 1'b0, 6, 1'b0);
		bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
		chk(v, 16'h8000);
		// idle again: frame sync leaves the lines released
		bus(1'b1, LSU_IDX_CTRL, 16'h0000, v);
		card.frame(48, 1'b0);
		chk_frame(-1, 1'b0, 6, 1'b0);
		// picking buffer 1 while idle swaps roles and restarts the fill at address 0
		bus(1'b1, LSU_IDX_CTRL, 16'h0022, v);
		bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
		chk(v, 16'h0000);
		q.delete();
		tx_data <= 8'hA5;
		tx_valid <= 1'b1;
		while (q.size() < 64) begin
			@(posedge clk);
			if (tx_ready_o === 1'b1) begin
				q.push_back(tx_data);
				tx_data <= 8'($urandom);
			end
		end
		tx_valid <= 1'b0;
		// two-line frame with double clock; group 0 is driven so a one is seen
		bus(1'b1, LSU_IDX_MASK_CLR, 16'hFFFF, v);
		m = 16'($urandom) | 16'h0001;
		bus(1'b1, LSU_IDX_MASK_SET, m, v);
		bus(1'b1, LSU_IDX_CTRL, 16'h0036, v);
		card.frame(256, 1'b1);
		chk_frame(0, 1'b1, 32, 1'b1);
		bus(1'b0, LSU_IDX_STAT, 16'h0000, v);
		chk(v, 16'h8000);
		// mid-run reset brings control and mask back to their reset values
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, LSU_IDX_CTRL, 16'h0000, v);
		chk(v, 16'h0002);
		bus(1'b0, LSU_IDX_MASK_RD, 16'h0000, v);
		chk(v, 16'h0000);
		end_of_test();
	end
endmodule : tb_top
